//--- irq_bank_regs.svh
// Purpose: Register indices, field positions, reset values and vectors
//          for the peripheral request flag and mask bank.
// Assumes: Included by its bare name wherever a constant is needed.
// Notes:   Byte address of a register is four times its index.
`ifndef IRQ_BANK_REGS_SVH
`define IRQ_BANK_REGS_SVH

// Width of the register bus address.
`define ADDR_W 12
// Bytes per register word, used to turn an index into a byte address.
`define WORD_BYTES 12'h004

// Register indices of the flag and mask registers.
`define IDX_TIMER_AB 12'h002
`define IDX_TIMER_C_CONV 12'h003
`define IDX_TIMER_D 12'h022
`define IDX_SERIAL 12'h023
// Register indices of the event status and event enable registers.
`define IDX_EVT_STATUS 12'h024
`define IDX_EVT_ENABLE 12'h025

// Bit positions of a flag and mask pair inside a 4-bit register.
`define BIT_FLAG_LO 0
`define BIT_MASK_LO 1
`define BIT_FLAG_HI 2
`define BIT_MASK_HI 3

// Source numbering, shared by the cells, status and request vectors.
`define NUM_SRC 6
`define SRC_TIMER_A 0
`define SRC_TIMER_B 1
`define SRC_TIMER_C 2
`define SRC_TIMER_D 3
`define SRC_SERIAL 4
`define SRC_CONV 5

// Reset values of the flags, masks and the event registers.
`define FLAG_RESET 1'b0
`define MASK_RESET 1'b1
`define EVT_RESET 6'h00

// Edge select bits for the timer D capture input.
`define EDGE_FALL 0
`define EDGE_RISE 1

// Vector addresses handed to the CPU, highest priority first.
`define VEC_TIMER_A 16'h0008
`define VEC_TIMER_BD 16'h000A
`define VEC_TIMER_C 16'h000C
`define VEC_SERIAL_CONV 16'h000E
`define VEC_NONE 16'h0000

// Bus answer codes and an empty data word.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define DATA_ZERO 32'h00000000
`define NIBBLE_ZERO 4'h0

`endif

//--- irq_bank_pkg.sv
// Purpose: Types shared by the request flag and mask bank.
// Assumes: The constants header is available to every file.
// Notes:   Bus signals travel as two packed structs.
`include "irq_bank_regs.svh"

package irq_bank_pkg;

    // Signals driven by the AXI4-Lite master.
    typedef struct packed {
        logic awvalid;
        logic [`ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [`ADDR_W-1:0] araddr;
        logic rready;
    } axil_req_t;

    // Signals driven by this slave.
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_t;

    // One-cycle event pulses and levels from the peripherals.
    typedef struct packed {
        logic timer_a_overflow;
        logic timer_b_overflow;
        logic timer_c_overflow;
        logic timer_d_overflow;
        logic timer_d_capture_mode;
        logic [1:0] timer_d_edge_sel;
        logic timer_d_event_input;
        logic serial_done;
        logic serial_halted;
        logic conversion_done;
    } periph_events_t;

    // Register selected by a bus address.
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_TIMER_AB,
        SEL_TIMER_C_CONV,
        SEL_TIMER_D,
        SEL_SERIAL,
        SEL_STATUS,
        SEL_ENABLE
    } reg_sel_t;

endpackage

//--- reset_sync.sv
// Purpose: Releases the asynchronous reset through two flip-flops.
// Assumes: arst_n_i may fall at any time; it rises unrelated to the clock.
// Notes:   Assertion is immediate, release is two edges late.
`timescale 1ns/1ps

module reset_sync (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    output logic rst_n_o
);

    // First stage; only the second stage reads it.
    logic stage1;
    // Second stage, the released reset.
    logic stage2;

    // Shift a one in after release so the release meets the clock cleanly.
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
        end else begin
            stage1 <= 1'b1;
            stage2 <= stage1;
        end
    end

    // The synchronised reset for the rest of the design.
    assign rst_n_o = stage2;

endmodule // reset_sync

//--- flag_mask_cell.sv
// Purpose: One request flag with its mask bit.
// Assumes: set_i is a one-cycle event pulse from the peripheral.
// Notes:   A peripheral event always beats a software write of the flag.
`timescale 1ns/1ps
`include "irq_bank_regs.svh"
module flag_mask_cell (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic set_i,
    input wire logic wr_i,
    input wire logic wr_flag_i,
    input wire logic wr_mask_i,
    output logic flag_o,
    output logic mask_o,
    output logic request_o
);

    // Next values of the flag and the mask.
    logic next_flag;
    logic next_mask;

    // The flag keeps its value until software writes it; an event wins.
    always_comb begin
        next_flag = flag_o;
        next_mask = mask_o;
        if (wr_i) begin
            next_flag = wr_flag_i;
            next_mask = wr_mask_i;
        end
        if (set_i) begin
            next_flag = 1'b1;
        end
    end

    // Register the flag and the mask.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_o <= `FLAG_RESET;
            mask_o <= `MASK_RESET;
        end else begin
            flag_o <= next_flag;
            mask_o <= next_mask;
        end
    end

    // A set flag is passed on only while its mask is clear.
    assign request_o = flag_o & ~mask_o;

endmodule // flag_mask_cell

//--- peripheral_irq_flag_mask_bank.sv
// Purpose: Request flags and masks of timers A to D, serial and converter,
//          with priority vector output and an AXI4-Lite register slave.
// Assumes: Event inputs are synchronous one-cycle pulses; the capture
//          input is a synchronous level.
// Notes:   Each register takes one word at four times its index.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "irq_bank_regs.svh"
module peripheral_irq_flag_mask_bank (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input irq_bank_pkg::axil_req_t axil_req_i,
    output irq_bank_pkg::axil_rsp_t axil_rsp_o,
    input irq_bank_pkg::periph_events_t events_i,
    input wire logic global_irq_enable_i,
    output logic [`NUM_SRC-1:0] request_o,
    output logic cpu_irq_request_o,
    output logic [15:0] vector_o,
    output logic irq_o
);

    import irq_bank_pkg::*;

    // Synchronised reset used by every register below.
    logic rst_n;

    // Write channel state: captured address, data and strobes.
    logic aw_held;
    logic [`ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic next_aw_held;
    logic [`ADDR_W-1:0] next_aw_addr;
    logic next_w_held;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;

    // Read channel state.
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    // Write performed in this cycle and the register it hits.
    logic do_write;
    reg_sel_t wr_sel;
    reg_sel_t rd_sel;

    // Per source: event, write strobe, written flag and mask, outputs.
    logic [`NUM_SRC-1:0] src_set;
    logic [`NUM_SRC-1:0] src_wr;
    logic [`NUM_SRC-1:0] src_wr_flag;
    logic [`NUM_SRC-1:0] src_wr_mask;
    logic [`NUM_SRC-1:0] src_flag;
    logic [`NUM_SRC-1:0] src_mask;
    logic [`NUM_SRC-1:0] src_req;

    // Previous level of the timer D capture input, for edge detection.
    logic capture_prev;
    logic next_capture_prev;
    logic capture_edge;

    // Sticky event status, its enable, and the registered outputs.
    logic [`NUM_SRC-1:0] evt_status;
    logic [`NUM_SRC-1:0] evt_enable;
    logic [`NUM_SRC-1:0] next_evt_status;
    logic [`NUM_SRC-1:0] next_evt_enable;
    logic [`NUM_SRC-1:0] next_request;
    logic next_cpu_irq_request;
    logic [15:0] next_vector;
    logic next_irq;

    // Map a byte address onto the register it names.
    function automatic reg_sel_t decode(input logic [`ADDR_W-1:0] addr);
        logic [`ADDR_W-3:0] word;
        word = addr[`ADDR_W-1:2];
        if (word == `IDX_TIMER_AB) begin
            decode = SEL_TIMER_AB;
        end else if (word == `IDX_TIMER_C_CONV) begin
            decode = SEL_TIMER_C_CONV;
        end else if (word == `IDX_TIMER_D) begin
            decode = SEL_TIMER_D;
        end else if (word == `IDX_SERIAL) begin
            decode = SEL_SERIAL;
        end else if (word == `IDX_EVT_STATUS) begin
            decode = SEL_STATUS;
        end else if (word == `IDX_EVT_ENABLE) begin
            decode = SEL_ENABLE;
        end else begin
            decode = SEL_NONE;
        end
    endfunction

    // Hold the design in reset until two edges after release.
    reset_sync u_reset_sync (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .rst_n_o(rst_n)
    );

    // Address and data are taken independently while no answer is out.
    assign axil_rsp_o.awready = ~aw_held & ~bvalid;
    assign axil_rsp_o.wready = ~w_held & ~bvalid;
    assign axil_rsp_o.bvalid = bvalid;
    assign axil_rsp_o.bresp = bresp;
    assign axil_rsp_o.arready = ~rvalid;
    assign axil_rsp_o.rvalid = rvalid;
    assign axil_rsp_o.rdata = rdata;
    assign axil_rsp_o.rresp = rresp;

    // The write is carried out once both halves are held.
    assign do_write = aw_held & w_held & ~bvalid;
    assign wr_sel = decode(aw_addr);
    assign rd_sel = decode(axil_req_i.araddr);

    // Next state of the write channel.
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        if (axil_req_i.awvalid && axil_rsp_o.awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = axil_req_i.awaddr;
        end
        if (axil_req_i.wvalid && axil_rsp_o.wready) begin
            next_w_held = 1'b1;
            next_w_data = axil_req_i.wdata;
            next_w_strb = axil_req_i.wstrb;
        end
        if (do_write) begin
            // Answer the write; an unmapped address gets an error.
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        end else if (bvalid && axil_req_i.bready) begin
            // The master has taken the answer.
            next_bvalid = 1'b0;
        end
    end

    // Register the write channel.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            w_held <= 1'b0;
            w_data <= `DATA_ZERO;
            w_strb <= `NIBBLE_ZERO;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
        end
    end

    // Next state of the read channel; data are sampled when taken.
    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (axil_req_i.arvalid && axil_rsp_o.arready) begin
            next_rvalid = 1'b1;
            next_rresp = `RESP_OKAY;
            next_rdata = `DATA_ZERO;
            unique case (rd_sel)
                SEL_TIMER_AB: begin
                    next_rdata[`BIT_FLAG_LO] = src_flag[`SRC_TIMER_A];
                    next_rdata[`BIT_MASK_LO] = src_mask[`SRC_TIMER_A];
                    next_rdata[`BIT_FLAG_HI] = src_flag[`SRC_TIMER_B];
                    next_rdata[`BIT_MASK_HI] = src_mask[`SRC_TIMER_B];
                end
                SEL_TIMER_C_CONV: begin
                    next_rdata[`BIT_FLAG_LO] = src_flag[`SRC_TIMER_C];
                    next_rdata[`BIT_MASK_LO] = src_mask[`SRC_TIMER_C];
                    next_rdata[`BIT_FLAG_HI] = src_flag[`SRC_CONV];
                    next_rdata[`BIT_MASK_HI] = src_mask[`SRC_CONV];
                end
                SEL_TIMER_D: begin
                    // Low two bits are unused and read as zero.
                    next_rdata[`BIT_FLAG_HI] = src_flag[`SRC_TIMER_D];
                    next_rdata[`BIT_MASK_HI] = src_mask[`SRC_TIMER_D];
                end
                SEL_SERIAL: begin
                    next_rdata[`BIT_FLAG_HI] = src_flag[`SRC_SERIAL];
                    next_rdata[`BIT_MASK_HI] = src_mask[`SRC_SERIAL];
                end
                SEL_STATUS: begin
                    next_rdata[`NUM_SRC-1:0] = evt_status;
                end
                SEL_ENABLE: begin
                    next_rdata[`NUM_SRC-1:0] = evt_enable;
                end
                SEL_NONE: begin
                    // Nothing lives here; answer with an error and zero.
                    next_rresp = `RESP_SLVERR;
                end
            endcase
        end else if (rvalid && axil_req_i.rready) begin
            next_rvalid = 1'b0;
        end
    end

    // Register the read channel.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rvalid <= 1'b0;
            rdata <= `DATA_ZERO;
            rresp <= `RESP_OKAY;
        end else begin
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    // Capture edges count only in input capture use, per edge select.
    always_comb begin
        next_capture_prev = events_i.timer_d_event_input;
        capture_edge = events_i.timer_d_capture_mode &
            ((events_i.timer_d_edge_sel[`EDGE_RISE] &
              events_i.timer_d_event_input & ~capture_prev) |
             (events_i.timer_d_edge_sel[`EDGE_FALL] &
              ~events_i.timer_d_event_input & capture_prev));
    end

    // Register the previous capture input level.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            capture_prev <= 1'b0;
        end else begin
            capture_prev <= next_capture_prev;
        end
    end

    // Route peripheral events and register writes to the flag cells.
    always_comb begin
        src_set[`SRC_TIMER_A] = events_i.timer_a_overflow;
        src_set[`SRC_TIMER_B] = events_i.timer_b_overflow;
        src_set[`SRC_TIMER_C] = events_i.timer_c_overflow;
        src_set[`SRC_TIMER_D] = events_i.timer_d_overflow |
            capture_edge;
        src_set[`SRC_SERIAL] = events_i.serial_done |
            events_i.serial_halted;
        src_set[`SRC_CONV] = events_i.conversion_done;
        src_wr = '0;
        src_wr_flag = '0;
        src_wr_mask = '0;
        if (do_write && w_strb[0]) begin
            unique case (wr_sel)
                SEL_TIMER_AB: begin
                    src_wr[`SRC_TIMER_A] = 1'b1;
                    src_wr[`SRC_TIMER_B] = 1'b1;
                end
                SEL_TIMER_C_CONV: begin
                    src_wr[`SRC_TIMER_C] = 1'b1;
                    src_wr[`SRC_CONV] = 1'b1;
                end
                SEL_TIMER_D: begin
                    src_wr[`SRC_TIMER_D] = 1'b1;
                end
                SEL_SERIAL: begin
                    src_wr[`SRC_SERIAL] = 1'b1;
                end
                SEL_STATUS, SEL_ENABLE, SEL_NONE: begin
                    // These registers hold no flag or mask pair.
                end
            endcase
        end
        // Software clears a serviced flag by writing zero to it.
        src_wr_flag[`SRC_TIMER_A] = w_data[`BIT_FLAG_LO];
        src_wr_mask[`SRC_TIMER_A] = w_data[`BIT_MASK_LO];
        src_wr_flag[`SRC_TIMER_B] = w_data[`BIT_FLAG_HI];
        src_wr_mask[`SRC_TIMER_B] = w_data[`BIT_MASK_HI];
        src_wr_flag[`SRC_TIMER_C] = w_data[`BIT_FLAG_LO];
        src_wr_mask[`SRC_TIMER_C] = w_data[`BIT_MASK_LO];
        src_wr_flag[`SRC_CONV] = w_data[`BIT_FLAG_HI];
        src_wr_mask[`SRC_CONV] = w_data[`BIT_MASK_HI];
        src_wr_flag[`SRC_TIMER_D] = w_data[`BIT_FLAG_HI];
        src_wr_mask[`SRC_TIMER_D] = w_data[`BIT_MASK_HI];
        src_wr_flag[`SRC_SERIAL] = w_data[`BIT_FLAG_HI];
        src_wr_mask[`SRC_SERIAL] = w_data[`BIT_MASK_HI];
    end

    // One flag and mask cell per source; masks gate the requests.
    for (genvar i = 0; i < `NUM_SRC; i++) begin : g_cell
        flag_mask_cell u_cell (
            .ref_clk_i(ref_clk_i),
            .rst_n_i(rst_n),
            .set_i(src_set[i]),
            .wr_i(src_wr[i]),
            .wr_flag_i(src_wr_flag[i]),
            .wr_mask_i(src_wr_mask[i]),
            .flag_o(src_flag[i]),
            .mask_o(src_mask[i]),
            .request_o(src_req[i])
        );
    end

    // Sticky event status, write-one-to-clear, and its enable register.
    always_comb begin
        next_evt_status = evt_status;
        next_evt_enable = evt_enable;
        if (do_write && w_strb[0] && wr_sel == SEL_STATUS) begin
            next_evt_status = evt_status & ~w_data[`NUM_SRC-1:0];
        end
        if (do_write && w_strb[0] && wr_sel == SEL_ENABLE) begin
            next_evt_enable = w_data[`NUM_SRC-1:0];
        end
        // A new event survives a clear in the same cycle.
        next_evt_status = next_evt_status | src_set;
    end

    // Requests, priority vector and interrupt output.
    always_comb begin
        next_request = src_req;
        // Handling starts only with the global enable set.
        next_cpu_irq_request = (|src_req) & global_irq_enable_i;
        next_irq = |(evt_status & evt_enable);
        // Highest priority pending request picks the vector.
        if (src_req[`SRC_TIMER_A]) begin
            next_vector = `VEC_TIMER_A;
        end else if (src_req[`SRC_TIMER_B] || src_req[`SRC_TIMER_D]) begin
            next_vector = `VEC_TIMER_BD;
        end else if (src_req[`SRC_TIMER_C]) begin
            next_vector = `VEC_TIMER_C;
        end else if (src_req[`SRC_SERIAL] || src_req[`SRC_CONV]) begin
            next_vector = `VEC_SERIAL_CONV;
        end else begin
            next_vector = `VEC_NONE;
        end
    end

    // Register the event registers and every data output.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            evt_status <= `EVT_RESET;
            evt_enable <= `EVT_RESET;
            request_o <= '0;
            cpu_irq_request_o <= 1'b0;
            vector_o <= `VEC_NONE;
            irq_o <= 1'b0;
        end else begin
            evt_status <= next_evt_status;
            evt_enable <= next_evt_enable;
            request_o <= next_request;
            cpu_irq_request_o <= next_cpu_irq_request;
            vector_o <= next_vector;
            irq_o <= next_irq;
        end
    end

endmodule // peripheral_irq_flag_mask_bank

//--- irq_bank_props.sv
// Purpose: Port checks for the request flag and mask bank.
// Assumes: Bound to the bank top module.
// Notes: The reset input disables every check.
`timescale 1ns/1ps
`include "irq_bank_regs.svh"

module irq_bank_props (
    input logic ref_clk_i,
    input logic arst_n_i,
    input irq_bank_pkg::axil_req_t axil_req_i,
    input irq_bank_pkg::axil_rsp_t axil_rsp_o,
    input irq_bank_pkg::periph_events_t events_i,
    input logic global_irq_enable_i,
    input logic [`NUM_SRC-1:0] request_o,
    input logic cpu_irq_request_o,
    input logic [15:0] vector_o,
    input logic irq_o
);
    import irq_bank_pkg::*;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    // The CPU line is the OR of requests gated by the enable.
    a_cpu_gate: assert property (
        cpu_irq_request_o == (|request_o && $past(global_irq_enable_i)))
        else $error("cpu gate");
    a_vec_top: assert property (
        request_o[0] |-> vector_o == `VEC_TIMER_A) else $error("vector A");
    a_vec_bd: assert property (
        !request_o[0] && (request_o[1] || request_o[3])
        |-> vector_o == `VEC_TIMER_BD) else $error("vector BD");
    a_vec_none: assert property (
        request_o == '0 |-> vector_o == `VEC_NONE) else $error("vector idle");
    // A request only drops right after a write answer.
    a_flag_sticky: assert property (
        |($past(request_o) & ~request_o) |-> $past(axil_rsp_o.bvalid))
        else $error("request dropped");
    a_event_wins: assert property (
        events_i.conversion_done |-> ##2
        (!$fell(request_o[5]) || $past(axil_rsp_o.bvalid)))
        else $error("converter lost");
    a_read_lat: assert property (
        axil_req_i.arvalid && axil_rsp_o.arready |=> axil_rsp_o.rvalid)
        else $error("read late");
    a_write_lat: assert property (
        axil_req_i.awvalid && axil_rsp_o.awready && axil_req_i.wvalid
        && axil_rsp_o.wready |=> !axil_rsp_o.bvalid ##1 axil_rsp_o.bvalid)
        else $error("write late");
    c_cpu: cover property (cpu_irq_request_o);
    c_irq: cover property (irq_o);
    c_low: cover property (vector_o == `VEC_SERIAL_CONV);
endmodule // irq_bank_props

bind peripheral_irq_flag_mask_bank irq_bank_props u_irq_bank_props (
    .ref_clk_i, .arst_n_i, .axil_req_i, .axil_rsp_o, .events_i,
    .global_irq_enable_i, .request_o, .cpu_irq_request_o, .vector_o,
    .irq_o);

//--- irq_periph_model.sv
// Purpose: Peripheral side: timer, serial and converter events.
// Assumes: A command is held for one clock.
// Notes: Pulses last one cycle; the capture line toggles and holds.
`timescale 1ns/1ps

module irq_periph_model (
    input wire logic ref_clk_i,
    input wire logic go_i,
    input wire logic [2:0] code_i,
    output irq_bank_pkg::periph_events_t events_o
);
    import irq_bank_pkg::*;
    logic [6:0] pulse;
    logic cap = 1'b0;
    initial events_o = '0;
    // Codes 0 to 6 give one pulse each; code 7 flips the capture input.
    always @(posedge ref_clk_i) begin
        pulse = go_i ? (7'h40 >> code_i) : 7'h00;
        cap = cap ^ (go_i && code_i == 3'h7);
        // Capture mode on, rising edges only: every other flip is ignored.
        events_o <= {pulse[6:3], 1'b1, 2'h2, cap, pulse[2:0]};
    end
endmodule // irq_periph_model

//--- testbench.sv
// Purpose: Self-checking bench for the request flag and mask bank.
// Assumes: Bus timing as the bank hands it over.
// Notes: A shadow model predicts every read and output.
`timescale 1ns/1ps
`include "irq_bank_regs.svh"

module testbench;
    import irq_bank_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, ie = 1'b0, go = 1'b0;
    logic [2:0] code = 3'h0;
    axil_req_t rq = '0;
    axil_rsp_t rs;
    periph_events_t ev;
    logic [5:0] req;
    logic cpu, irq;
    logic [15:0] vec;
    logic [11:0] a;
    logic [31:0] v, d;
    logic [1:0] r;
    int s;
    bit h;
    bit [5:0] fl = '0, mk = '1, st = '0, en = '0;
    int err_total = 0, samples_checked = 0, cyc = 0, seed = 50;
    int smap[8] = '{0, 1, 2, 3, 4, 4, 5, 3};
    logic [11:0] at[7] = '{12'h008, 12'h00C, 12'h088, 12'h08C, 12'h090,
        12'h094, 12'h0A0};

    always #5 clk = ~clk;

    peripheral_irq_flag_mask_bank u_peripheral_irq_flag_mask_bank (
        .ref_clk_i(clk), .arst_n_i(rst_n), .axil_req_i(rq), .axil_rsp_o(rs),
        .events_i(ev), .global_irq_enable_i(ie), .request_o(req),
        .cpu_irq_request_o(cpu), .vector_o(vec), .irq_o(irq));
    irq_periph_model u_irq_periph_model (.ref_clk_i(clk), .go_i(go),
        .code_i(code), .events_o(ev));

    // Register image predicted from the shadow state.
    function automatic logic [31:0] ex(input logic [11:0] x);
        case (x)
            12'h008: ex = {mk[1], fl[1], mk[0], fl[0]};
            12'h00C: ex = {mk[5], fl[5], mk[2], fl[2]};
            12'h088: ex = {mk[3], fl[3], 2'h0};
            12'h08C: ex = {mk[4], fl[4], 2'h0};
            12'h090: ex = st;
            12'h094: ex = en;
            default: ex = `DATA_ZERO;
        endcase
    endfunction

    // Highest pending source picks the vector.
    function automatic logic [15:0] vx(input logic [5:0] q);
        if (q[0]) return `VEC_TIMER_A;
        if (q[1] | q[3]) return `VEC_TIMER_BD;
        if (q[2]) return `VEC_TIMER_C;
        if (q[4] | q[5]) return `VEC_SERIAL_CONV;
        return `VEC_NONE;
    endfunction

    task automatic chk(input string n, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic outs();
        chk("req", fl & ~mk, req);
        chk("vector", vx(fl & ~mk), vec);
        chk("cpu", (|(fl & ~mk)) & ie, cpu);
        chk("irq", |(st & en), irq);
    endtask

    // Write with address and data offered together.
    task automatic wr(input logic [11:0] x, input logic [31:0] y);
        logic ta, tw, bk;
        @(posedge clk);
        rq.awaddr <= x;
        rq.wdata <= y;
        {rq.awvalid, rq.wvalid, rq.bready} <= 3'h7;
        do begin
            @(negedge clk);
            {ta, tw, bk, r} = {rs.awready, rs.wready, rs.bvalid, rs.bresp};
            @(posedge clk);
            if (ta) rq.awvalid <= 1'b0;
            if (tw) rq.wvalid <= 1'b0;
            if (bk) rq.bready <= 1'b0;
        end while (!bk);
    endtask

    task automatic rd(input logic [11:0] x);
        logic ta, tr;
        @(posedge clk);
        rq.araddr <= x;
        {rq.arvalid, rq.rready} <= 2'h3;
        do begin
            @(negedge clk);
            {ta, tr, d, r} = {rs.arready, rs.rvalid, rs.rdata, rs.rresp};
            @(posedge clk);
            if (ta) rq.arvalid <= 1'b0;
            if (tr) rq.rready <= 1'b0;
        end while (!tr);
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        rq.wstrb = 4'hF;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        // Reset image of every register, then an unmapped place.
        foreach (at[k]) begin
            rd(at[k]);
            chk("reset read", ex(at[k]), d);
            chk("read resp", (k == 6) ? `RESP_SLVERR : `RESP_OKAY, r);
        end
        // Every event code and a random write; from pass 16 the event
        // lands in the cycle in which the write is carried out.
        for (int i = 0; i < 32; i++) begin
            a = at[i % 6];
            v = $random(seed);
            if (i % 6 < 4) v = v & (ex(a) | 32'hA);
            s = smap[i % 8];
            // Passes 15 and 31 drop the capture line: no rising edge.
            h = (i % 16 != 15);
            fork
                begin
                    if (i < 16) repeat (8) @(posedge clk);
                    wr(a, v);
                end
                begin
                    @(posedge clk);
                    go <= 1'b1;
                    code <= 3'(i);
                    ie <= 1'($random(seed));
                    @(posedge clk);
                    go <= 1'b0;
                end
            join
            if (i < 16) fl[s] = fl[s] | h;
            if (i < 16) st[s] = st[s] | h;
            chk("write resp", `RESP_OKAY, r);
            case (a)
                12'h008: {mk[1], fl[1], mk[0], fl[0]} = v[3:0];
                12'h00C: {mk[5], fl[5], mk[2], fl[2]} = v[3:0];
                12'h088: {mk[3], fl[3]} = v[3:2];
                12'h08C: {mk[4], fl[4]} = v[3:2];
                12'h090: st = st & ~v[5:0];
                default: en = v[5:0];
            endcase
            // Late passes: the event beats the write in the same cycle.
            if (i >= 16) fl[s] = fl[s] | h;
            if (i >= 16) st[s] = st[s] | h;
            rd(a);
            chk("flag read", ex(a), d);
            rd(12'h090);
            chk("status", ex(12'h090), d);
            @(negedge clk);
            outs();
        end
        complete_run();
    end

    // Cuts a hang short.
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            err_total++;
            complete_run();
        end
    end
endmodule // testbench
